// [core/cpu_status_pkg.sv]
/*
 status flags and memory map constants for the 8-bit core.
 assumes a single 20 MHz system clock domain.
*/
package cpu_status_pkg;
	localparam logic [7:0]  PAGE_REG_ADDR   = 8'hE1;
	localparam logic [2:0]  PAGE_REG_MASK   = 3'h7;
	localparam logic [2:0]  PAGE_REG_RESET  = 3'h0;
	localparam logic [7:0]  CTRL_LO         = 8'hC0;
	localparam logic [15:0] RESET_VEC       = 16'hFFFE;
	localparam logic [15:0] EXT0_VEC        = 16'hFFFC;
	localparam logic [15:0] TABLE_TOP       = 16'hFFDE;
	localparam logic [15:0] PAGE_CALL_BASE  = 16'hFF00;
	localparam logic [15:0] VEC_STEP        = 16'h0002;
	localparam logic [8:0]  UPPER_PAGE_BASE = 9'h100;
	localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

	// instruction-level operations that change flags or flow
	typedef enum logic [15:0] {
		OP_NONE   = 16'h0001,
		OP_UNMASK = 16'h0002,
		OP_MASK   = 16'h0004,
		OP_OVERFLOW_CLEAR_INSTRUCTION   = 16'h0008,
		OP_UPPER_PAGE_SELECT_INSTRUCTION   = 16'h0010,
		OP_LOWER_PAGE_SELECT_INSTRUCTION   = 16'h0020,
		OP_ADD    = 16'h0040,
		OP_SUB    = 16'h0080,
		OP_XFER   = 16'h0100,
		OP_MTEST  = 16'h0200,
		OP_TRAP   = 16'h0400,
		OP_TJUMP  = 16'h0800,
		OP_PJUMP  = 16'h1000,
		OP_CALL   = 16'h2000,
		OP_RET    = 16'h4000,
		OP_HANDLER_EXIT_INSTRUCTION   = 16'h8000
	} op_t;

	typedef struct packed {
		logic n;
		logic v;
		logic g;
		logic b;
		logic h;
		logic i;
		logic z;
		logic c;
	} status_t;

	typedef enum logic [3:0] {
		ST_RUN    = 4'h1,
		ST_VEC_LO = 4'h2,
		ST_VEC_HI = 4'h4,
		ST_STACK  = 4'h8
	} state_t;
endpackage : cpu_status_pkg

// [core/cpu_status_core.sv]
/*
 processor status word, program counter, vector fetch, stack pointer
 and data page selection of the 8-bit core.
 assumes program memory answers a read in the same cycle, and that
 the decoder supplies one op per cycle only while op_ready is high.
*/
`timescale 1ns/1ns
module cpu_status_core (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	// decoded operation
	input  wire cpu_status_pkg::op_t   op,
	input  wire logic [7:0]            op_a,
	input  wire logic [7:0]            op_b,
	input  wire logic [7:0]            operand,
	input  wire logic [15:0]           call_target,
	input  wire logic [3:0]            table_index,
	input  wire logic [7:0]            stack_in,
	output logic                       op_ready,
	// interrupt request
	input  wire logic                  irq_req,
	input  wire logic [3:0]            irq_source,
	output logic                       irq_ack,
	// program memory
	output logic [15:0]                prog_addr,
	input  wire logic [7:0]            prog_data,
	// data side
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	output logic [8:0]                 direct_addr,
	output logic [15:0]                paged_addr,
	output logic                       ctrl_sel,
	// stack
	input  wire logic                  sp_load,
	input  wire logic [7:0]            sp_value,
	output logic [7:0]                 sp,
	output logic [7:0]                 stack_out,
	output logic                       stack_we,
	// state
	output cpu_status_pkg::status_t    status,
	output logic [15:0]                pc
);
	cpu_status_pkg::state_t  state;
	cpu_status_pkg::state_t  next_state;
	logic [15:0]             vec_addr;
	logic [7:0]              vec_lo;
	logic [2:0]              page_reg;
	logic [1:0]              push_cnt;
	logic [7:0]              push_hi;
	logic [7:0]              push_lo;
	logic [7:0]              push_st;
	logic [15:0]             ret_addr;

	function automatic logic [15:0] vec_of(input logic [3:0] idx,
		input logic [15:0] top);
		vec_of = top - {11'h000, idx, 1'b0};
	endfunction : vec_of

	// arithmetic results
	wire logic [8:0] sum      = {1'b0, op_a} + {1'b0, op_b};
	wire logic [8:0] diff     = {1'b0, op_a} - {1'b0, op_b};
	wire logic [4:0] lo_sum   = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
	wire logic [4:0] lo_diff  = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]};
	wire logic       add_ovf  = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
	wire logic       sub_ovf  = (op_a[7] != op_b[7]) && (diff[7] != op_a[7]);
	wire logic       take_irq = irq_req && status.i
		&& state == cpu_status_pkg::ST_RUN;
	wire logic       is_trap  = op == cpu_status_pkg::OP_TRAP
		&& state == cpu_status_pkg::ST_RUN;
	wire logic       is_tjump = op == cpu_status_pkg::OP_TJUMP
		&& state == cpu_status_pkg::ST_RUN;
	wire logic       is_call  = (op == cpu_status_pkg::OP_CALL
		|| op == cpu_status_pkg::OP_PJUMP)
		&& state == cpu_status_pkg::ST_RUN;
	wire logic [15:0] pjump_target = cpu_status_pkg::PAGE_CALL_BASE
		| {8'h00, operand};
	wire logic       page_hit = reg_addr == cpu_status_pkg::PAGE_REG_ADDR;
	// direct operand decode, so the window follows the page flag
	wire logic       ctrl_hit = operand >= cpu_status_pkg::CTRL_LO;

	// next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			cpu_status_pkg::ST_RUN:
				if (take_irq || is_trap || is_tjump)
					next_state = cpu_status_pkg::ST_VEC_LO;
				else if (is_call)
					next_state = cpu_status_pkg::ST_STACK;
			cpu_status_pkg::ST_VEC_LO:
				next_state = cpu_status_pkg::ST_VEC_HI;
			cpu_status_pkg::ST_VEC_HI:
				next_state = (push_cnt != 2'd0)
					? cpu_status_pkg::ST_STACK : cpu_status_pkg::ST_RUN;
			cpu_status_pkg::ST_STACK:
				if (push_cnt <= 2'd1)
					next_state = cpu_status_pkg::ST_RUN;
			default:
				next_state = cpu_status_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			state <= cpu_status_pkg::ST_VEC_LO;
		else
			state <= next_state;

	// vector slot address
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			vec_addr <= cpu_status_pkg::RESET_VEC;
		else if (take_irq)
			vec_addr <= vec_of(irq_source, cpu_status_pkg::EXT0_VEC);
		else if (is_tjump || is_trap)
			vec_addr <= vec_of(is_trap ? 4'h0 : table_index,
				cpu_status_pkg::TABLE_TOP);

	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			vec_lo <= 8'h00;
		else if (state == cpu_status_pkg::ST_VEC_LO)
			vec_lo <= prog_data;

	// program counter; natural 16-bit wrap
	assign ret_addr = pc + 16'h0001;
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			pc <= 16'h0000;
		else if (state == cpu_status_pkg::ST_VEC_HI)
			pc <= {prog_data, vec_lo};
		else if (is_call)
			pc <= (op == cpu_status_pkg::OP_PJUMP)
				? pjump_target : call_target;
		else if (state == cpu_status_pkg::ST_RUN
			&& op == cpu_status_pkg::OP_RET)
			pc <= {stack_in, operand};
		else if (state == cpu_status_pkg::ST_RUN
			&& op == cpu_status_pkg::OP_HANDLER_EXIT_INSTRUCTION)
			pc <= {stack_in, operand};
		else if (state == cpu_status_pkg::ST_RUN
			&& op != cpu_status_pkg::OP_NONE)
			pc <= ret_addr;

	assign prog_addr = (state == cpu_status_pkg::ST_VEC_HI)
		? vec_addr + 16'h0001 : (state == cpu_status_pkg::ST_VEC_LO
		? vec_addr : pc);

	// return address capture: interrupts also save flags
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			push_cnt <= 2'd0;
			push_hi  <= 8'h00;
			push_lo  <= 8'h00;
			push_st  <= 8'h00;
		end
		else if (take_irq || is_trap || is_call)
		begin
			push_cnt <= (take_irq || is_trap) ? 2'd3 : 2'd2;
			push_hi  <= ret_addr[15:8];
			push_lo  <= ret_addr[7:0];
			push_st  <= status;
		end
		else if (state == cpu_status_pkg::ST_STACK && push_cnt != 2'd0)
		begin
			push_cnt <= push_cnt - 2'd1;
			push_hi  <= push_lo;
			push_lo  <= push_st;
		end

	// decrement, then save at sp; restore reads at sp, then increments
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			sp <= 8'h00; // hardware leaves it to software
		else if (sp_load)
			sp <= sp_value;
		else if (state == cpu_status_pkg::ST_STACK && push_cnt != 2'd0)
			sp <= sp - 8'h01;
		else if (state == cpu_status_pkg::ST_RUN
			&& (op == cpu_status_pkg::OP_RET
			|| op == cpu_status_pkg::OP_HANDLER_EXIT_INSTRUCTION))
			sp <= sp + ((op == cpu_status_pkg::OP_HANDLER_EXIT_INSTRUCTION)
				? 8'h03 : 8'h02);

	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			stack_we  <= 1'b0;
			stack_out <= 8'h00;
		end
		else
		begin
			stack_we  <= state == cpu_status_pkg::ST_STACK
				&& push_cnt != 2'd0;
			stack_out <= push_hi;
		end

	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			irq_ack  <= 1'b0;
			op_ready <= 1'b0;
		end
		else
		begin
			irq_ack  <= take_irq;
			op_ready <= next_state == cpu_status_pkg::ST_RUN;
		end

	// status flags
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			status <= '0;
		else if (take_irq)
			status.i <= 1'b0;
		else if (state == cpu_status_pkg::ST_RUN)
			unique case (op)
				cpu_status_pkg::OP_UNMASK: status.i <= 1'b1;
				cpu_status_pkg::OP_MASK:   status.i <= 1'b0;
				cpu_status_pkg::OP_OVERFLOW_CLEAR_INSTRUCTION:
				begin
					status.v <= 1'b0;
					status.h <= 1'b0;
				end
				cpu_status_pkg::OP_UPPER_PAGE_SELECT_INSTRUCTION:   status.g <= 1'b1;
				cpu_status_pkg::OP_LOWER_PAGE_SELECT_INSTRUCTION:   status.g <= 1'b0;
				cpu_status_pkg::OP_ADD:
				begin
					status.h <= lo_sum[4];
					status.v <= add_ovf;
					status.n <= sum[7];
					status.z <= sum[7:0] == 8'h00;
					status.c <= sum[8];
				end
				cpu_status_pkg::OP_SUB:
				begin
					status.h <= !lo_diff[4];
					status.v <= sub_ovf;
					status.n <= diff[7];
					status.z <= diff[7:0] == 8'h00;
					status.c <= !diff[8];
				end
				cpu_status_pkg::OP_XFER:
				begin
					status.n <= op_a[7];
					status.z <= op_a == 8'h00;
				end
				cpu_status_pkg::OP_MTEST:
				begin
					status.v <= op_a[6];
					status.n <= op_a[7];
				end
				cpu_status_pkg::OP_TRAP:
				begin
					status.b <= 1'b1;
					status.i <= 1'b0;
				end
				cpu_status_pkg::OP_HANDLER_EXIT_INSTRUCTION:   status <= stack_in;
				default: ;
			endcase

	// page register, three bits held
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			page_reg <= cpu_status_pkg::PAGE_REG_RESET;
		else if (reg_wr && page_hit)
			page_reg <= reg_wdata[2:0] & cpu_status_pkg::PAGE_REG_MASK;

	// other control addresses read a fixed value, writes dropped
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= page_hit ? {5'h00, page_reg}
				: cpu_status_pkg::UNMAPPED_READ;

	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			ctrl_sel    <= 1'b0;
			direct_addr <= 9'h000;
			paged_addr  <= 16'h0000;
		end
		else
		begin
			ctrl_sel    <= ctrl_hit && !status.g;
			direct_addr <= status.g
				? (cpu_status_pkg::UPPER_PAGE_BASE | {1'b0, operand})
				: {1'b0, operand};
			paged_addr  <= status.g ? {5'h00, page_reg, operand}
				: {8'h00, operand};
		end
endmodule : cpu_status_core

// [bench/cpu_status_assertions.sv]
/*
 checker for flag, vector and page register timing of the core.
 assumes it is bound into cpu_status_core, one clock domain.
*/
`timescale 1ns/1ns
module cpu_status_assertions (
	// clock and reset
	input wire logic                    sys_clk,
	input wire logic                    arst_n,
	// watched ports
	input wire cpu_status_pkg::op_t     op,
	input wire logic [7:0]              op_a,
	input wire logic                    op_ready,
	input wire logic                    irq_ack,
	input wire logic [15:0]             prog_addr,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_addr,
	input wire logic [7:0]              reg_rdata,
	input wire cpu_status_pkg::status_t status
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// one-hot op bits, only while ready
	wire logic [15:0] taken;
	assign taken = op_ready ? op : 16'h0000;
	sequence s_vec;
		prog_addr == 16'hFFFE ##1 prog_addr == 16'hFFFF;
	endsequence
	AST_RESET_VEC: assert property ($rose(arst_n) |-> s_vec)
		else $error("reset vector fetch order wrong");
	AST_UNMASK: assert property (taken[1] |=> status.i)
		else $error("unmask left interrupts off");
	AST_MASK: assert property (taken[2] |=> !status.i)
		else $error("mask left interrupts on");
	AST_NO_ACK: assert property (!status.i |=> !irq_ack)
		else $error("interrupt taken while masked");
	AST_ACK_CLR: assert property (irq_ack |-> !status.i)
		else $error("interrupt flag not cleared on accept");
	AST_OVERFLOW_CLEAR_INSTRUCTION: assert property (taken[3] |=> !status.v && !status.h)
		else $error("overflow clear missed a flag");
	AST_PAGE_SET: assert property (taken[4] |=> status.g)
		else $error("upper page not selected");
	AST_PAGE_CLR: assert property (taken[5] |=> !status.g)
		else $error("lower page not selected");
	AST_XFER_N: assert property (taken[8] |=> status.n == $past(op_a[7]))
		else $error("negative flag not result bit 7");
	AST_MTEST: assert property (taken[9] |=> status.v == $past(op_a[6])
		&& status.n == $past(op_a[7]))
		else $error("memory test copied wrong bits");
	AST_TRAP: assert property (taken[10] |=> status.b)
		else $error("trap left break flag clear");
	AST_PAGE_RD: assert property (reg_rd && reg_addr == 8'hE1
		|=> reg_rdata[7:3] == 5'h00)
		else $error("page register upper bits not zero");
endmodule : cpu_status_assertions

bind cpu_status_core cpu_status_assertions i_cpu_status_assertions (
	.sys_clk, .arst_n, .op, .op_a, .op_ready, .irq_ack, .prog_addr,
	.reg_rd, .reg_addr, .reg_rdata, .status
);

// [bench/prog_mem_model.sv]
/*
 program memory model: each byte is the inverse of its address low
 byte, so every two-byte vector is easy to predict.
 assumes the core wants same-cycle read data.
*/
`timescale 1ns/1ns
module prog_mem_model (
	// fetch
	input wire logic [15:0] prog_addr,
	output logic     [7:0]  prog_data
);
	// low byte at the slot, high byte at slot plus one
	assign prog_data = ~prog_addr[7:0];
endmodule : prog_mem_model

// [bench/cpu_status_core_tb.sv]
/*
 self-checking bench for cpu_status_core: flag table, page register,
 interrupt, return and vector jumps.
 assumes prog_mem_model answers fetches and the checker is bound.
*/
`timescale 1ns/1ns
module cpu_status_core_tb;
	typedef struct packed {
		cpu_status_pkg::op_t op;
		logic [7:0]          a;
		logic [7:0]          b;
		logic [7:0]          mask;
		logic [7:0]          want;
	} row_t;
	cpu_status_pkg::op_t     op;
	cpu_status_pkg::status_t status;
	logic [15:0] pc, prog_addr, paged_addr, call_target;
	logic [8:0]  direct_addr;
	logic [7:0]  op_a, op_b, operand, stack_in, prog_data, reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, sp_value, sp, stack_out;
	logic [3:0]  table_index, irq_source;
	logic        sys_clk, arst_n, op_ready, irq_req, irq_ack, reg_wr;
	logic        reg_rd, ctrl_sel, sp_load, stack_we;
	int          n_fail, comparisons, pushes, acks;
	row_t        rows [9];

	cpu_status_core i_cpu_status_core (.sys_clk, .arst_n, .op, .op_a,
		.op_b, .operand, .call_target, .table_index, .stack_in,
		.op_ready, .irq_req, .irq_source, .irq_ack, .prog_addr,
		.prog_data, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.direct_addr, .paged_addr, .ctrl_sel, .sp_load, .sp_value, .sp,
		.stack_out, .stack_we, .status, .pc);
	prog_mem_model i_prog_mem_model (.prog_addr, .prog_data);

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		pushes += (stack_we === 1'b1);
		acks += (irq_ack === 1'b1);
	end

	task automatic check(input logic [15:0] got, input logic [15:0] want);
		comparisons++;
		if (got !== want)
		begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : check

	// inputs move 5 ns after the edge, away from sampling
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask : tick

	task automatic wait_ready;
		int k;
		k = 0;
		while (op_ready !== 1'b1 && k < 40)
		begin
			tick(1);
			k++;
		end
	endtask : wait_ready

	task automatic issue(input cpu_status_pkg::op_t o);
		wait_ready;
		op = o;
		tick(1);
		op = cpu_status_pkg::OP_NONE;
		// idle edge so the next call never re-drives op at once
		tick(1);
	endtask : issue

	// vector ops drop ready while they fetch
	task automatic vec(input cpu_status_pkg::op_t o);
		issue(o);
		tick(1);
		wait_ready;
	endtask : vec

	task automatic reg_access(input logic wr, input logic [7:0] a, d);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 0;
		reg_rd = 0;
		tick(1);
	endtask : reg_access

	task automatic test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	initial
	begin
		#50000;
		n_fail++;
		test_done;
	end

	initial
	begin
		{sys_clk, arst_n, irq_req, reg_wr, reg_rd, sp_load} = '0;
		{op_a, op_b, operand, stack_in, reg_addr, reg_wdata} = '0;
		{sp_value, table_index, irq_source, call_target} = '0;
		{n_fail, comparisons, pushes, acks} = '0;
		op = cpu_status_pkg::OP_NONE;
		rows = '{
			'{cpu_status_pkg::OP_UNMASK, 8'h00, 8'h00, 8'h04, 8'h04},
			'{cpu_status_pkg::OP_MASK,   8'h00, 8'h00, 8'h04, 8'h00},
			'{cpu_status_pkg::OP_UPPER_PAGE_SELECT_INSTRUCTION,   8'h00, 8'h00, 8'h20, 8'h20},
			'{cpu_status_pkg::OP_LOWER_PAGE_SELECT_INSTRUCTION,   8'h00, 8'h00, 8'h20, 8'h00},
			'{cpu_status_pkg::OP_ADD,    8'h7F, 8'h01, 8'hC8, 8'hC8},
			'{cpu_status_pkg::OP_OVERFLOW_CLEAR_INSTRUCTION,   8'h00, 8'h00, 8'h48, 8'h00},
			'{cpu_status_pkg::OP_SUB,    8'h80, 8'h01, 8'hC0, 8'h40},
			'{cpu_status_pkg::OP_XFER,   8'h80, 8'h00, 8'h80, 8'h80},
			'{cpu_status_pkg::OP_MTEST,  8'h40, 8'h00, 8'hC0, 8'h40}};
		tick(8);
		arst_n = 1;
		wait_ready;
		check(pc, 16'h0001);
		check(16'(status), 16'h0000);
		$display("reset test done");
		foreach (rows[r])
		begin
			op_a = rows[r].a;
			op_b = rows[r].b;
			issue(rows[r].op);
			check(16'(status & rows[r].mask), 16'(rows[r].want));
		end
		$display("flag table done");
		reg_access(1, 8'hE1, 8'hFF);
		reg_access(0, 8'hE1, 8'h00);
		check(16'(reg_rdata), 16'h0007);
		issue(cpu_status_pkg::OP_UPPER_PAGE_SELECT_INSTRUCTION);
		operand = 8'h35;
		tick(2);
		check(paged_addr, 16'h0735);
		check(16'(direct_addr), 16'h0135);
		issue(cpu_status_pkg::OP_LOWER_PAGE_SELECT_INSTRUCTION);
		operand = 8'hC4;
		tick(2);
		check(16'(direct_addr), 16'h00C4);
		check(16'(ctrl_sel), 16'h0001);
		operand = 8'hBF;
		tick(2);
		check(16'(ctrl_sel), 16'h0000);
		$display("page test done");
		sp_value = 8'hFF;
		sp_load = 1;
		tick(1);
		sp_load = 0;
		irq_source = 4'h1;
		irq_req = 1;
		tick(4);
		check(16'(acks), 16'h0000);
		issue(cpu_status_pkg::OP_UNMASK);
		tick(1);
		irq_req = 0;
		wait_ready;
		tick(3);
		check(pc, 16'h0405);
		check(16'(acks), 16'h0001);
		check(16'(status.i), 16'h0000);
		check(16'(pushes), 16'h0003);
		check(16'(sp), 16'h00FC);
		operand = 8'h34;
		stack_in = 8'h12;
		vec(cpu_status_pkg::OP_RET);
		check(pc, 16'h1234);
		check(16'(sp), 16'h00FE);
		$display("interrupt test done");
		vec(cpu_status_pkg::OP_TRAP);
		check(pc, 16'h2021);
		check(16'(status.b), 16'h0001);
		table_index = 4'h1;
		vec(cpu_status_pkg::OP_TJUMP);
		check(pc, 16'h2223);
		operand = 8'h35;
		issue(cpu_status_pkg::OP_PJUMP);
		check(pc, 16'hFF35);
		$display("jump test done");
		test_done;
	end
endmodule : cpu_status_core_tb
